// ==== core/pcs_supervisor.sv ====
// Control and supervision around the jitter-attenuating loop.
// Assumes clocks arrive as levels sampled on mclk and a host loads cfg.
//
// How it works
// - Source is input 1, input 2 or crystal.
// - Each input and output has own divider.
// - Host loads dividers and settings as one cfg word on a strobe.
// - Loop bandwidth chosen from 60 Hz to 8.4 kHz.
// - Input switch lands on new input edge.
// - Manual, revertive or non-revertive automatic selection.
// - Per-input signal missing alarm on missing pulses.
// - Lock from selected input versus feedback phase.
// - Alarm when input frequency leaves allowed band.
// - Offset band chosen between two threshold styles.
// - Lost input enters hold at historical average.
// - Hold keeps tracking the crystal reference.
// - Each output has its own signal format.
// - Second output can be powered down.
// - Coarse offset moves phase 200 ps steps.
// - Fine offset spans +/-108 ps in 3 ps.
// - Output to output skew step 800 ps-2.2 ns.
// - Bypass drives output straight from input.
// - Outputs off until first calibration ends.
// - With squelch, off until lock is held after a finished calibration.
// - Forced on keeps outputs running throughout.
// - Calibration ends lock lost within 1200 ms.
// - Missing pulse caught within 4.5 divided periods.
`timescale 1ns/1ps
module pcs_supervisor #(
  parameter int unsigned LOCK_CYCLES = pcs_pkg::LOCK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cfgLoad,
  input wire pcs_pkg::pcs_cfg_type cfg,
  input wire logic calStart,
  input wire logic [1:0] inputClock,
  input wire logic feedbackClock,
  input wire logic synthClock,
  output logic [1:0] outputClock,
  output logic [1:0] outputEnable,
  output pcs_pkg::pcs_fmt_type [1:0] outputFormat,
  output pcs_pkg::pcs_status_type status,
  output logic alarmInput1Pin,
  output logic alarmInput2Pin,
  output logic [pcs_pkg::PER_W-1:0] freqWord,
  output logic signed [17:0] phaseOffsetPs,
  output logic [11:0] outputSkewPs,
  output logic [13:0] bandwidthHz
);
  ////////////////////////////////////////////////////////////////////////////
  // Configuration, reloaded only on the host's load strobe.
  pcs_pkg::pcs_cfg_type cfg_q, cfg_d;
  always_comb begin
    cfg_d = cfgLoad ? cfg : cfg_q;
  end
  always_ff @(posedge mclk) begin
    cfg_q <= !reset_n ? pcs_pkg::CFG_RESET : cfg_d;
  end

  // Settings double from 60 Hz upward; the upper half all pins the widest bandwidth.
  function automatic logic [13:0] bwDecode(input logic [3:0] sel);
    return sel[3] ? 14'h20D0 : 14'h003C << sel[2:0];
  endfunction : bwDecode

  ////////////////////////////////////////////////////////////////////////////
  // Per-input monitors: period, gap, divided edge and alarms.
  logic [1:0] inPrev_q, inPrev_d, rise, divEdge;
  logic [1:0] missing_q, missing_d, fos_q, fos_d;
  logic [pcs_pkg::GAP_W-1:0] gap_q [2], gap_d [2], thr [2];
  logic [pcs_pkg::PER_W-1:0] per_q [2], per_d [2];
  logic [pcs_pkg::DIV_W-1:0] divCnt_q [2], divCnt_d [2];

  for (genvar i = 0; i < 2; i++) begin : g_in
    logic [pcs_pkg::PER_W-1:0] dev;
    logic [pcs_pkg::PER_W-1:0] tol;
    logic [pcs_pkg::DIV_W-1:0] div;
    always_comb begin
      div = (cfg_q.inDiv[i] == '0) ? pcs_pkg::DIV_W'(1) : cfg_q.inDiv[i];
      inPrev_d[i] = inputClock[i];
      rise[i] = inputClock[i] & ~inPrev_q[i];
      // Threshold is 4.5 input periods per divider count, halved after x9.
      thr[i] = (pcs_pkg::GAP_W'(per_q[i]) * pcs_pkg::GAP_W'(div) * pcs_pkg::LOS_MULT) >> 1;
      gap_d[i] = rise[i] ? '0 : (&gap_q[i] ? gap_q[i] : gap_q[i] + 1'b1);
      per_d[i] = !rise[i] ? per_q[i] : (|gap_q[i][pcs_pkg::GAP_W-1:pcs_pkg::PER_W]) ? '1
                 : gap_q[i][pcs_pkg::PER_W-1:0] + 1'b1;
      divEdge[i] = rise[i] && (divCnt_q[i] >= div - 1'b1);
      divCnt_d[i] = rise[i] ? (divEdge[i] ? '0 : divCnt_q[i] + 1'b1) : divCnt_q[i];
      missing_d[i] = rise[i] ? 1'b0 : (gap_q[i] > thr[i]) ? 1'b1 : missing_q[i];
      dev = (per_d[i] > cfg_q.expPeriod[i]) ? per_d[i] - cfg_q.expPeriod[i]
            : cfg_q.expPeriod[i] - per_d[i];
      tol = cfg_q.minimumClockThreshold ? cfg_q.expPeriod[i] >> pcs_pkg::FOS_SHIFT_SMC
            : cfg_q.expPeriod[i] >> pcs_pkg::FOS_SHIFT_STRATUM;
      fos_d[i] = rise[i] ? (dev > tol) : fos_q[i];
    end
    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        inPrev_q[i] <= 1'b0;
        gap_q[i] <= '0;
        per_q[i] <= '0;
        divCnt_q[i] <= '0;
        missing_q[i] <= 1'b1;
        fos_q[i] <= 1'b0;
      end else begin
        inPrev_q[i] <= inPrev_d[i];
        gap_q[i] <= gap_d[i];
        per_q[i] <= per_d[i];
        divCnt_q[i] <= divCnt_d[i];
        missing_q[i] <= missing_d[i];
        fos_q[i] <= fos_d[i];
      end
    end
    a_los_set: assert property (@(posedge mclk) disable iff (!reset_n)
      !rise[i] && gap_q[i] > thr[i] |=> missing_q[i])
      else $error("missing pulse not flagged");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and hold.
  pcs_pkg::pcs_src_type src_q, src_d;
  logic [pcs_pkg::PER_W-1:0] avg_q, avg_d;
  logic pref, other, prefOk, otherOk;
  pcs_pkg::pcs_src_type want;
  always_comb begin
    pref = cfg_q.prefInput;
    other = ~pref;
    prefOk = ~missing_q[pref];
    otherOk = ~missing_q[other];
    want = src_q;
    if (cfg_q.freeRun) begin
      want = pcs_pkg::SRC_XTAL;
    end else begin
      case (cfg_q.selMode)
        pcs_pkg::MODE_MANUAL: want = prefOk ? pcs_pkg::pcs_src_type'({1'b0, pref})
                                     : pcs_pkg::SRC_HOLD;
        pcs_pkg::MODE_AUTO_NONREV: begin
          if (src_q[1] || missing_q[src_q[0]]) begin
            want = prefOk ? pcs_pkg::pcs_src_type'({1'b0, pref})
                   : otherOk ? pcs_pkg::pcs_src_type'({1'b0, other}) : pcs_pkg::SRC_HOLD;
          end
        end
        default: want = prefOk ? pcs_pkg::pcs_src_type'({1'b0, pref})
                        : otherOk ? pcs_pkg::pcs_src_type'({1'b0, other})
                        : pcs_pkg::SRC_HOLD;
      endcase
    end
    src_d = src_q;
    // Landing on the new input's own edge keeps the output phase step small.
    if (want != src_q && (want[1] || divEdge[want[0]])) begin
      src_d = want;
    end
    avg_d = avg_q;
    if (!src_q[1] && divEdge[src_q[0]]) begin
      avg_d = avg_q + (per_q[src_q[0]] >> pcs_pkg::HIST_SHIFT)
              - (avg_q >> pcs_pkg::HIST_SHIFT);
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      src_q <= pcs_pkg::SRC_XTAL;
      avg_q <= '0;
    end else begin
      src_q <= src_d;
      avg_q <= avg_d;
    end
  end
  a_hold_entry: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_q.selMode == pcs_pkg::MODE_MANUAL && !cfg_q.freeRun && missing_q[cfg_q.prefInput]
    |=> src_q == pcs_pkg::SRC_HOLD)
    else $error("hold not entered on lost input");
  a_revert: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_q.selMode == pcs_pkg::MODE_AUTO_REV && !cfg_q.freeRun && !cfgLoad
    && !missing_q[cfg_q.prefInput] && divEdge[cfg_q.prefInput] && !$changed(cfg_q)
    |=> src_q == pcs_pkg::pcs_src_type'({1'b0, $past(cfg_q.prefInput)}))
    else $error("revertive mode did not return");

  ////////////////////////////////////////////////////////////////////////////
  // Lock detection and calibration.
  logic signed [7:0] ph_q, ph_d;
  logic fbPrev_q, fbPrev_d, fbRise, inWin;
  logic lol_q, lol_d, cal_q, cal_d, calDone_q, calDone_d, calOk_q, calOk_d;
  logic [9:0] settle_q, settle_d;
  logic [pcs_pkg::LOCK_W-1:0] calCnt_q, calCnt_d;
  always_comb begin
    fbPrev_d = feedbackClock;
    fbRise = feedbackClock & ~fbPrev_q;
    ph_d = ph_q;
    if (cal_q && calCnt_q == '0) begin
      ph_d = '0;
    end else if (!src_q[1] && divEdge[src_q[0]] && !fbRise) begin
      ph_d = ph_q + 8'sd1;
    end else if (fbRise && !(!src_q[1] && divEdge[src_q[0]])) begin
      ph_d = ph_q - 8'sd1;
    end
    inWin = (ph_q <= $signed(pcs_pkg::LOCK_SLIP)) && (ph_q >= -$signed(pcs_pkg::LOCK_SLIP));
    settle_d = inWin ? (settle_q == pcs_pkg::LOCK_SETTLE ? settle_q : settle_q + 1'b1) : '0;
    lol_d = lol_q;
    if (cal_q || !inWin) begin
      lol_d = 1'b1;
    end else if (settle_q == pcs_pkg::LOCK_SETTLE) begin
      lol_d = 1'b0;
    end
    cal_d = cal_q;
    calCnt_d = cal_q ? calCnt_q + 1'b1 : '0;
    calDone_d = calDone_q;
    calOk_d = calOk_q;
    if (calStart) begin
      cal_d = 1'b1;
      calCnt_d = '0;
    end else if (cal_q && (settle_q == pcs_pkg::LOCK_SETTLE
                 || calCnt_q == pcs_pkg::LOCK_W'(LOCK_CYCLES - 1))) begin
      cal_d = 1'b0;
      calDone_d = 1'b1;
    end
    if (!cal_q && calDone_q && !lol_q) begin
      calOk_d = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ph_q <= '0;
      fbPrev_q <= 1'b0;
      settle_q <= '0;
      lol_q <= 1'b1;
      cal_q <= 1'b0;
      calCnt_q <= '0;
      calDone_q <= 1'b0;
      calOk_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      fbPrev_q <= fbPrev_d;
      settle_q <= settle_d;
      lol_q <= lol_d;
      cal_q <= cal_d;
      calCnt_q <= calCnt_d;
      calDone_q <= calDone_d;
      calOk_q <= calOk_d;
    end
  end
  a_cal_lol: assert property (@(posedge mclk) disable iff (!reset_n)
    cal_q |=> lol_q)
    else $error("lock reported during calibration");
  a_cal_bound: assert property (@(posedge mclk) disable iff (!reset_n)
    cal_q && !calStart && calCnt_q == pcs_pkg::LOCK_W'(LOCK_CYCLES - 1) |=> !cal_q)
    else $error("calibration overran its limit");

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: gating, dividers, bypass and offsets.
  logic [1:0] outEn_d, outClk_d;
  logic [1:0] outTog_q, outTog_d;
  logic [pcs_pkg::DIV_W-1:0] outCnt_q [2], outCnt_d [2];
  logic synPrev_q, synRise, outOn, selRaw;
  logic signed [14:0] fineClamp;
  always_comb begin
    synRise = synthClock & ~synPrev_q;
    selRaw = src_q[1] ? 1'b0 : inputClock[src_q[0]];
    // Squelch waits for lock; otherwise any finished calibration suffices.
    outOn = cfg_q.outputsForcedOn
            || (cfg_q.squelchUntilCalibrated ? calOk_q : calDone_q);
    outEn_d = {outOn && !cfg_q.powerDown2, outOn};
    for (int k = 0; k < 2; k++) begin
      outTog_d[k] = outTog_q[k];
      outCnt_d[k] = outCnt_q[k];
      if (synRise) begin
        outCnt_d[k] = (outCnt_q[k] + 1'b1 >= cfg_q.outDiv[k]) ? '0 : outCnt_q[k] + 1'b1;
        outTog_d[k] = (outCnt_d[k] == '0) ? ~outTog_q[k] : outTog_q[k];
      end
      outClk_d[k] = outEn_d[k] && (cfg_q.bypass ? selRaw : outTog_q[k]);
    end
    fineClamp = $signed(cfg_q.finePhaseOffset);
    if (fineClamp > pcs_pkg::FINE_MAX_STEPS) begin
      fineClamp = pcs_pkg::FINE_MAX_STEPS;
    end else if (fineClamp < -pcs_pkg::FINE_MAX_STEPS) begin
      fineClamp = -pcs_pkg::FINE_MAX_STEPS;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      synPrev_q <= 1'b0;
      outTog_q <= '0;
      outCnt_q <= '{default: '0};
      outputEnable <= '0;
      outputClock <= '0;
      phaseOffsetPs <= '0;
      outputSkewPs <= pcs_pkg::SKEW_MIN_PS;
      bandwidthHz <= '0;
      outputFormat <= '{default: pcs_pkg::FMT_LVPECL};
    end else begin
      synPrev_q <= synthClock;
      outTog_q <= outTog_d;
      outCnt_q <= outCnt_d;
      outputEnable <= outEn_d;
      outputClock <= outClk_d;
      phaseOffsetPs <= $signed(18'(cfg_q.coarsePhaseOffset) * pcs_pkg::COARSE_STEP_PS)
                       + 18'(fineClamp) * $signed(pcs_pkg::FINE_STEP_PS);
      outputSkewPs <= (cfg_q.skewSteps > 4'hE) ? pcs_pkg::SKEW_MAX_PS
                      : pcs_pkg::SKEW_MIN_PS + 12'(cfg_q.skewSteps) * pcs_pkg::SKEW_INC_PS;
      bandwidthHz <= bwDecode(cfg_q.bwSel);
      outputFormat <= cfg_q.format;
    end
  end
  always_comb begin
    status.signalMissing = missing_q;
    status.frequencyOffsetAlarm = fos_q;
    status.lockLost = lol_q;
    status.calActive = cal_q;
    status.holdActive = (src_q == pcs_pkg::SRC_HOLD);
    status.trackXtal = src_q[1];
    status.source = src_q;
    alarmInput1Pin = missing_q[0];
    alarmInput2Pin = missing_q[1];
    freqWord = src_q[1] ? avg_q : per_q[src_q[0]];
  end
  a_squelch_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg_q.outputsForcedOn && cfg_q.squelchUntilCalibrated && !calOk_q |=> outputEnable == 2'b00)
    else $error("outputs ran before lock");
  a_precal_off: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg_q.outputsForcedOn && !calDone_q |=> !outputEnable[0])
    else $error("outputs ran before calibration");
  a_forced_on: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_q.outputsForcedOn ##1 cfg_q.outputsForcedOn |-> outputEnable[0])
    else $error("forced outputs not running");
  a_pd_second: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_q.powerDown2 |=> !outputEnable[1] && !outputClock[1])
    else $error("second output not powered down");
  a_bypass_path: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_q.bypass && outEn_d[0] |=> outputClock[0] == $past(selRaw))
    else $error("bypass output not from input");
endmodule : pcs_supervisor

// ==== dv/pcs_clock_model.sv ====
// Model of the two input reference clocks and the loop feedback clock.
// Assumes mclk is far faster than the clocks that it makes here.
`timescale 1ns/1ps
module pcs_clock_model #(
  parameter int HALF = 32
) (
  input wire logic mclk,
  input wire logic [1:0] run,
  output logic [1:0] inputClock,
  output logic feedbackClock,
  output logic synthClock
);
  int cnt [2] = '{0, 0};
  logic [1:0] synthCnt = 2'b00;
  logic [1:0] clkQ = 2'b00;

  //////////////////////////////////////////////////////////////////////////////
  // A stopped input stands still low, as a dead source would.
  always @(posedge mclk) begin
    synthCnt <= synthCnt + 2'b01;
    for (int i = 0; i < 2; i++) begin
      if (run[i] && cnt[i] == HALF - 1) begin
        clkQ[i] <= ~clkQ[i];
        cnt[i] <= 0;
      end else if (run[i]) begin
        cnt[i] <= cnt[i] + 1;
      end else begin
        clkQ[i] <= 1'b0;
        cnt[i] <= 0;
      end
    end
  end
  assign inputClock = clkQ;

  //////////////////////////////////////////////////////////////////////////////
  // A locked loop returns the first input's phase as its feedback.
  assign feedbackClock = inputClock[0];
  assign synthClock = synthCnt[1];
endmodule : pcs_clock_model

// ==== dv/pcs_supervisor_bench.sv ====
// Self-checking bench of the clock supervisor.
// Assumes the clock model drives the input, feedback and synth clocks.
`timescale 1ns/1ps
module pcs_supervisor_bench;
  localparam int HALF = 32;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cfgLoad = 1'b0;
  logic calStart = 1'b0;
  logic [1:0] run = 2'b00;
  pcs_pkg::pcs_cfg_type cfgV = pcs_pkg::CFG_RESET;
  pcs_pkg::pcs_cfg_type cfg = pcs_pkg::CFG_RESET;
  logic [1:0] inputClock, outputClock, outputEnable;
  logic feedbackClock, synthClock, alarmInput1Pin, alarmInput2Pin;
  pcs_pkg::pcs_fmt_type [1:0] outputFormat;
  pcs_pkg::pcs_status_type status;
  logic [pcs_pkg::PER_W-1:0] freqWord;
  logic signed [17:0] phaseOffsetPs;
  logic [11:0] outputSkewPs;
  logic [13:0] bandwidthHz;
  int errors = 0;
  int checkCount = 0;
  int cycles = 0;

  //////////////////////////////////////////////////////////////////////////////
  // A short lock limit keeps the run brief; it still exceeds the settle window.
  pcs_supervisor #(.LOCK_CYCLES(2000)) i_dut (.mclk(mclk), .reset_n(reset_n),
    .cfgLoad(cfgLoad), .cfg(cfg), .calStart(calStart), .inputClock(inputClock),
    .feedbackClock(feedbackClock), .synthClock(synthClock), .outputClock(outputClock),
    .outputEnable(outputEnable), .outputFormat(outputFormat), .status(status),
    .alarmInput1Pin(alarmInput1Pin), .alarmInput2Pin(alarmInput2Pin), .freqWord(freqWord),
    .phaseOffsetPs(phaseOffsetPs), .outputSkewPs(outputSkewPs), .bandwidthHz(bandwidthHz));
  pcs_clock_model #(.HALF(HALF)) i_clocks (.mclk(mclk), .run(run), .inputClock(inputClock),
    .feedbackClock(feedbackClock), .synthClock(synthClock));

  initial begin
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  // The whole struct is handed over at one edge, then derived outputs settle.
  task automatic load();
    @(negedge mclk);
    cfg = cfgV;
    cfgLoad = 1'b1;
    @(negedge mclk);
    cfgLoad = 1'b0;
    idle(3);
  endtask : load

  task automatic do_reset();
    @(negedge mclk);
    reset_n = 1'b0;
    idle(12);
    reset_n = 1'b1;
    idle(2);
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check("enable", 18'(outputEnable), 18'h0_0000);
    check("missing", 18'(status.signalMissing), 18'h0_0003);
    check("lockLost", 18'(status.lockLost), 18'h0_0001);
    // Manual selection with no live preferred input falls into hold at the first edge.
    check("source", 18'(status.source), 18'(pcs_pkg::SRC_HOLD));
    check("skew", 18'(outputSkewPs), 18'h0_0320);
  endtask : test_reset

  task automatic test_phase();
    cfgV = pcs_pkg::CFG_RESET;
    cfgV.coarsePhaseOffset = 8'h03;
    cfgV.finePhaseOffset = 15'h0005;
    cfgV.skewSteps = 4'hF;
    cfgV.bwSel = 4'h8;
    cfgV.format = {pcs_pkg::FMT_CML, pcs_pkg::FMT_CMOS};
    load();
    check("phase", phaseOffsetPs, 18'h0_0267);
    check("skew", 18'(outputSkewPs), 18'h0_0898);
    check("bw", 18'(bandwidthHz), 18'h0_20D0);
    check("format", 18'(outputFormat), 18'h0_000B);
    cfgV.coarsePhaseOffset = 8'h00;
    cfgV.finePhaseOffset = 15'h0064;
    cfgV.skewSteps = 4'h2;
    cfgV.bwSel = 4'h3;
    load();
    check("phase", phaseOffsetPs, 18'h0_006C);
    check("skew", 18'(outputSkewPs), 18'h0_03E8);
    check("bw", 18'(bandwidthHz), 18'h0_01E0);
  endtask : test_phase

  // A stopped first input must raise its alarm and drop manual selection into hold.
  task automatic test_missing();
    int n;
    cfgV = pcs_pkg::CFG_RESET;
    load();
    run = 2'b11;
    idle(300);
    check("missing", 18'(status.signalMissing), 18'h0_0000);
    check("source", 18'(status.source), 18'(pcs_pkg::SRC_IN1));
    check("freq", 18'(freqWord), 18'(2 * HALF));
    run = 2'b10;
    // Threshold is period * divider * 4.5 cycles after the last rise.
    for (n = 0; n < 2 * HALF * 9 / 2 + 4 && alarmInput1Pin !== 1'b1; n++) @(negedge mclk);
    check("pin1", 18'(alarmInput1Pin), 18'h0_0001);
    check("pin2", 18'(alarmInput2Pin), 18'h0_0000);
    idle(2);
    check("hold", 18'(status.holdActive), 18'h0_0001);
    check("track", 18'(status.trackXtal), 18'h0_0001);
    check("source", 18'(status.source), 18'(pcs_pkg::SRC_HOLD));
  endtask : test_missing

  task automatic test_select();
    cfgV.selMode = pcs_pkg::MODE_AUTO_NONREV;
    load();
    idle(200);
    check("source", 18'(status.source), 18'(pcs_pkg::SRC_IN2));
    run = 2'b11;
    idle(300);
    check("source", 18'(status.source), 18'(pcs_pkg::SRC_IN2));
    cfgV.selMode = pcs_pkg::MODE_AUTO_REV;
    load();
    idle(200);
    check("source", 18'(status.source), 18'(pcs_pkg::SRC_IN1));
    cfgV.freeRun = 1'b1;
    load();
    check("source", 18'(status.source), 18'(pcs_pkg::SRC_XTAL));
  endtask : test_select

  // Period is 64 cycles; 66 exceeds the tight band but not the wide one.
  task automatic test_fos();
    cfgV = pcs_pkg::CFG_RESET;
    cfgV.expPeriod = {12'h040, 12'h042};
    load();
    idle(200);
    check("fos", 18'(status.frequencyOffsetAlarm), 18'h0_0001);
    cfgV.minimumClockThreshold = 1'b1;
    load();
    idle(200);
    check("fos", 18'(status.frequencyOffsetAlarm), 18'h0_0000);
  endtask : test_fos

  task automatic test_cal();
    int n;
    cfgV = pcs_pkg::CFG_RESET;
    cfgV.squelchUntilCalibrated = 1'b1;
    load();
    idle(200);
    check("enable", 18'(outputEnable), 18'h0_0000);
    calStart = 1'b1;
    @(negedge mclk);
    calStart = 1'b0;
    check("calActive", 18'(status.calActive), 18'h0_0001);
    // Lock lost is raised from the registered calibration flag, one edge later.
    @(negedge mclk);
    check("lockLost", 18'(status.lockLost), 18'h0_0001);
    for (n = 0; n < 2100 && status.lockLost !== 1'b0; n++) @(negedge mclk);
    check("lockLost", 18'(status.lockLost), 18'h0_0000);
    idle(3);
    check("enable", 18'(outputEnable), 18'h0_0003);
    cfgV.powerDown2 = 1'b1;
    load();
    check("enable", 18'(outputEnable), 18'h0_0001);
  endtask : test_cal

  // Bypass shows the selected input one edge late on both outputs.
  task automatic test_forced();
    int n;
    logic prev;
    do_reset();
    cfgV = pcs_pkg::CFG_RESET;
    cfgV.outputsForcedOn = 1'b1;
    load();
    check("enable", 18'(outputEnable), 18'h0_0003);
    check("lockLost", 18'(status.lockLost), 18'h0_0001);
    cfgV.bypass = 1'b1;
    load();
    idle(200);
    check("source", 18'(status.source), 18'(pcs_pkg::SRC_IN1));
    for (n = 0; n < 64; n++) begin
      prev = inputClock[0];
      @(negedge mclk);
      check("bypass", 18'(outputClock), 18'({prev, prev}));
    end
  endtask : test_forced

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(12);
    check("source", 18'(status.source), 18'(pcs_pkg::SRC_XTAL));
    reset_n = 1'b1;
    idle(2);
    test_reset();
    test_phase();
    test_missing();
    test_select();
    test_fos();
    test_cal();
    test_forced();
    test_done();
  end
endmodule : pcs_supervisor_bench

// ==== include/pcs_pkg.sv ====
// Shared constants and carriers of the clock supervisor.
// Assumes one 50 MHz clock domain and inputs sampled as synchronous levels.
package pcs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned LOCK_TIME_MS = 1200;
  localparam int unsigned LOCK_CYCLES = LOCK_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_W = 26;
  localparam int unsigned GAP_W = 24;
  localparam int unsigned PER_W = 12;
  localparam int unsigned DIV_W = 8;
  localparam logic [GAP_W-1:0] LOS_MULT = 24'h00_0009;
  localparam int unsigned FOS_SHIFT_STRATUM = 6;
  localparam int unsigned FOS_SHIFT_SMC = 5;
  localparam logic [7:0] LOCK_SLIP = 8'h04;
  localparam logic [9:0] LOCK_SETTLE = 10'h3_FF;
  localparam int unsigned HIST_SHIFT = 4;
  localparam logic [17:0] COARSE_STEP_PS = 18'h0_00C8;
  localparam logic [17:0] FINE_STEP_PS = 18'h0_0003;
  localparam logic signed [14:0] FINE_MAX_STEPS = 15'h0024;
  localparam logic [11:0] SKEW_MIN_PS = 12'h320;
  localparam logic [11:0] SKEW_MAX_PS = 12'h898;
  localparam logic [11:0] SKEW_INC_PS = 12'h064;

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00, MODE_AUTO_REV = 2'b01, MODE_AUTO_NONREV = 2'b10
  } pcs_mode_type;
  typedef enum logic [1:0] {
    SRC_IN1 = 2'b00, SRC_IN2 = 2'b01, SRC_XTAL = 2'b10, SRC_HOLD = 2'b11
  } pcs_src_type;
  typedef enum logic [1:0] {
    FMT_LVPECL = 2'b00, FMT_LVDS = 2'b01, FMT_CML = 2'b10, FMT_CMOS = 2'b11
  } pcs_fmt_type;

  typedef struct packed {
    logic [1:0][DIV_W-1:0] inDiv;
    logic [1:0][DIV_W-1:0] outDiv;
    logic [1:0][PER_W-1:0] expPeriod;
    logic [3:0] bwSel;
    pcs_mode_type selMode;
    logic prefInput;
    logic freeRun;
    logic minimumClockThreshold;
    logic outputsForcedOn;
    logic squelchUntilCalibrated;
    logic bypass;
    logic powerDown2;
    pcs_fmt_type [1:0] format;
    logic [7:0] coarsePhaseOffset;
    logic [14:0] finePhaseOffset;
    logic [3:0] skewSteps;
  } pcs_cfg_type;

  localparam pcs_cfg_type CFG_RESET = '{
    inDiv: {8'h01, 8'h01}, outDiv: {8'h01, 8'h01}, expPeriod: {12'h000, 12'h000},
    bwSel: 4'h0, selMode: MODE_MANUAL, prefInput: 1'b0, freeRun: 1'b0,
    minimumClockThreshold: 1'b0, outputsForcedOn: 1'b0, squelchUntilCalibrated: 1'b0,
    bypass: 1'b0, powerDown2: 1'b0, format: {FMT_LVPECL, FMT_LVPECL},
    coarsePhaseOffset: 8'h00, finePhaseOffset: 15'h0000, skewSteps: 4'h0};

  typedef struct packed {
    logic [1:0] signalMissing;
    logic [1:0] frequencyOffsetAlarm;
    logic lockLost;
    logic calActive;
    logic holdActive;
    logic trackXtal;
    pcs_src_type source;
  } pcs_status_type;
endpackage : pcs_pkg
